// file: hw/dpb_regs.svh
// constants shared by the burst sram interface files
`ifndef DPB_REGS_SVH
`define DPB_REGS_SVH

// narrow configuration word width; the wide configuration uses 36
`define DPB_WORD_W_NARROW 18
`define DPB_WORD_W_WIDE 36
// address bits of the flip-flop array by default, 256 locations (the real array is far deeper)
`define DPB_ADDR_W 8
// two words move per address on every access
`define DPB_BURST_LEN 2
// command and return buffers
`define DPB_FIFO_DEPTH 8
// stages of every reset synchroniser
`define DPB_SYNC_STAGES 2

`endif

// file: hw/dpb_pkg.sv
// types shared by the burst sram interface
package dpb_pkg;

    // what one captured clock period asks of the array
    typedef enum logic [1:0] {
        DPB_OP_NONE,
        DPB_OP_READ,
        DPB_OP_WRITE,
        DPB_OP_BOTH
    } dpb_op_t;

endpackage : dpb_pkg

// file: hw/dpb_fifo.sv
// dual-clock fifo with gray-coded pointers, valid and ready on both sides
`timescale 1ns/10ps
`include "dpb_regs.svh"

module dpb_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = `DPB_FIFO_DEPTH
) (
    // filling side
    input  wire logic             wr_clk,
    input  wire logic             wr_resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    input  wire logic             rd_clk,
    input  wire logic             rd_resetn,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0]      wr_bin;
    logic [AW:0]      rd_bin;
    logic [AW:0]      wr_gray;
    logic [AW:0]      rd_gray;
    logic [AW:0]      wr_gray_s1;
    logic [AW:0]      wr_gray_s2;
    logic [AW:0]      rd_gray_s1;
    logic [AW:0]      rd_gray_s2;
    logic             push;
    logic             pop;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        to_gray = b ^ (b >> 1);
    endfunction : to_gray

    assign wr_gray   = to_gray(wr_bin);
    assign rd_gray   = to_gray(rd_bin);
    // full when the write pointer is one lap ahead of the read pointer
    assign in_ready  = (wr_gray != {~rd_gray_s2[AW:AW-1], rd_gray_s2[AW-2:0]});
    assign out_valid = (rd_gray != wr_gray_s2);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_bin[AW-1:0]];

    always_ff @(posedge wr_clk) begin
        if (push) begin
            mem[wr_bin[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge wr_clk or negedge wr_resetn) begin
        if (!wr_resetn) begin
            wr_bin <= '0;
        end else if (push) begin
            wr_bin <= wr_bin + 1'b1;
        end
    end

    always_ff @(posedge wr_clk or negedge wr_resetn) begin
        if (!wr_resetn) begin
            rd_gray_s1 <= '0;
            rd_gray_s2 <= '0;
        end else begin
            rd_gray_s1 <= rd_gray;
            rd_gray_s2 <= rd_gray_s1;
        end
    end

    always_ff @(posedge rd_clk or negedge rd_resetn) begin
        if (!rd_resetn) begin
            rd_bin <= '0;
        end else if (pop) begin
            rd_bin <= rd_bin + 1'b1;
        end
    end

    always_ff @(posedge rd_clk or negedge rd_resetn) begin
        if (!rd_resetn) begin
            wr_gray_s1 <= '0;
            wr_gray_s2 <= '0;
        end else begin
            wr_gray_s1 <= wr_gray;
            wr_gray_s2 <= wr_gray_s1;
        end
    end

endmodule : dpb_fifo

// file: hw/dpb_sram.sv
// burst sram interface: ddr input capture, array core and ddr read launch
`timescale 1ns/10ps
`include "dpb_regs.svh"

// Behaviour
// - Reads leave on their own output pins and writes arrive on their own input pins, sharing one address bus.
// - The read address is taken at the rising edge of the true input clock and the write address at the rising edge of the complementary one.
// - Every location holds two words that always move as a two-word burst, 18 bits wide by default or 36 wide.
// - One word moves on each rising edge of the true and of the complementary clock, on input and on output.
// - Address, selects and write data are all caught in input registers on the input clock pair.
// - Read data leaves from registers on the output clock pair, which is tied to the input pair in single-clock use.
// - Accepted writes finish inside the device with no strobe timing from the controller.
// - A read and a write may be in flight at once and neither waits for the other.
// - Each port has its own select so the controller can enable one port of one device among several.
// - A read always returns the most recent write to its location, even a write still in flight.
// - A pair of echo clocks runs beside the read data so the controller can catch the burst words.
// - Only rising edges of the true and complementary clocks and of the core clock sample anything.
module dpb_sram #(
    parameter int DATA_W     = `DPB_WORD_W_NARROW,
    parameter int ADDR_W     = `DPB_ADDR_W,
    parameter int FIFO_DEPTH = `DPB_FIFO_DEPTH
) (
    // core clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // input clock pair from the controller
    input  wire logic              clk_k,
    input  wire logic              clk_kn,
    // output clock pair from the controller
    input  wire logic              clk_c,
    input  wire logic              clk_cn,
    // shared address and port selects
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              read_sel_n,
    input  wire logic              write_sel_n,
    // write data port
    input  wire logic [DATA_W-1:0] d,
    // read data port, one word per output clock phase
    output logic [DATA_W-1:0]      q_rise,
    output logic [DATA_W-1:0]      q_fall,
    output logic                   q_valid,
    // echo clocks
    output logic                   echo_clock,
    output logic                   echo_clock_n,
    // command lost because the core fell behind
    output logic                   overrun
);

    localparam int BURST_W = `DPB_BURST_LEN * DATA_W;
    localparam int DEPTH   = 1 << ADDR_W;
    // command entry: read flag, write flag, read address, write address, word1, word0
    localparam int W0_LSB  = 0;
    localparam int W1_LSB  = W0_LSB + DATA_W;
    localparam int WA_LSB  = W1_LSB + DATA_W;
    localparam int RA_LSB  = WA_LSB + ADDR_W;
    localparam int WR_BIT  = RA_LSB + ADDR_W;
    localparam int RD_BIT  = WR_BIT + 1;
    localparam int CMD_W   = RD_BIT + 1;

    // one decode of the two port flags, used on both sides of the crossing
    function automatic dpb_pkg::dpb_op_t op_of(input logic rd, input logic wr);
        dpb_pkg::dpb_op_t op;
        op = dpb_pkg::DPB_OP_NONE;
        if (rd && wr) begin
            op = dpb_pkg::DPB_OP_BOTH;
        end else if (rd) begin
            op = dpb_pkg::DPB_OP_READ;
        end else if (wr) begin
            op = dpb_pkg::DPB_OP_WRITE;
        end
        return op;
    endfunction : op_of

    // complementary input clock phase
    logic              kn_wr;
    logic [ADDR_W-1:0] kn_waddr;
    logic [DATA_W-1:0] kn_w0;

    // true input clock phase
    logic              k_rd;
    logic              k_wr;
    logic [ADDR_W-1:0] k_raddr;
    logic [ADDR_W-1:0] k_waddr;
    logic [DATA_W-1:0] k_w0;
    logic [DATA_W-1:0] k_w1;
    dpb_pkg::dpb_op_t  k_op;
    logic              cmd_in_valid;
    logic              cmd_in_ready;
    logic [CMD_W-1:0]  cmd_in_data;

    // core side
    logic              cmd_out_valid;
    logic              cmd_out_ready;
    logic [CMD_W-1:0]  cmd_out_data;
    dpb_pkg::dpb_op_t  sys_op;
    logic              sys_rd;
    logic              sys_wr;
    logic [ADDR_W-1:0] sys_raddr;
    logic [ADDR_W-1:0] sys_waddr;
    logic [BURST_W-1:0] sys_wburst;
    logic [BURST_W-1:0] sys_rburst;
    logic              sys_fire;
    logic [BURST_W-1:0] mem [0:DEPTH-1];

    // return path
    logic              ret_in_valid;
    logic              ret_in_ready;
    logic              ret_out_valid;
    logic [BURST_W-1:0] ret_out_data;

    // output clock pair
    logic [DATA_W-1:0] c_w1;

    // the pin drops every domain at once, but each domain leaves reset only
    // on its own edges, so no flop comes out of reset inside its setup window
    localparam int DOM_SYS = 0;
    localparam int DOM_K   = 1;
    localparam int DOM_KN  = 2;
    localparam int DOM_C   = 3;
    localparam int DOM_CN  = 4;
    localparam int N_DOM   = 5;
    localparam int SYNC_N  = `DPB_SYNC_STAGES;

    logic [N_DOM-1:0]  dom_clk;
    logic [N_DOM-1:0]  dom_resetn;
    logic              sys_resetn;
    logic              k_resetn;
    logic              kn_resetn;
    logic              c_resetn;
    logic              cn_resetn;

    assign dom_clk    = {clk_cn, clk_c, clk_kn, clk_k, clk_sys};
    assign sys_resetn = dom_resetn[DOM_SYS];
    assign k_resetn   = dom_resetn[DOM_K];
    assign kn_resetn  = dom_resetn[DOM_KN];
    assign c_resetn   = dom_resetn[DOM_C];
    assign cn_resetn  = dom_resetn[DOM_CN];

    for (genvar g = 0; g < N_DOM; g++) begin : g_rst_sync
        logic [SYNC_N-1:0] stage;

        always_ff @(posedge dom_clk[g] or negedge resetn) begin
            if (!resetn) begin
                stage <= '0;
            end else begin
                stage <= {stage[SYNC_N-2:0], 1'b1};
            end
        end

        assign dom_resetn[g] = stage[SYNC_N-1];
    end

    // ---------------------------------------------------------------
    // input capture, complementary phase: write select, address, word 0
    // ---------------------------------------------------------------
    always_ff @(posedge clk_kn or negedge kn_resetn) begin
        if (!kn_resetn) begin
            kn_wr <= 1'b0;
        end else begin
            kn_wr <= !write_sel_n;
        end
    end

    // unselected slots leave the held address and data untouched
    always_ff @(posedge clk_kn or negedge kn_resetn) begin
        if (!kn_resetn) begin
            kn_waddr <= '0;
            kn_w0    <= '0;
        end else if (!write_sel_n) begin
            kn_waddr <= addr;
            kn_w0    <= d;
        end
    end

    // ---------------------------------------------------------------
    // input capture, true phase: read select, read address, word 1
    // ---------------------------------------------------------------
    always_ff @(posedge clk_k or negedge k_resetn) begin
        if (!k_resetn) begin
            k_rd    <= 1'b0;
            k_raddr <= '0;
        end else begin
            k_rd <= !read_sel_n;
            if (!read_sel_n) begin
                k_raddr <= addr;
            end
        end
    end

    // the second write word follows its address by half a clock
    always_ff @(posedge clk_k or negedge k_resetn) begin
        if (!k_resetn) begin
            k_wr    <= 1'b0;
            k_waddr <= '0;
            k_w0    <= '0;
            k_w1    <= '0;
        end else begin
            k_wr <= kn_wr;
            if (kn_wr) begin
                k_waddr <= kn_waddr;
                k_w0    <= kn_w0;
                k_w1    <= d;
            end
        end
    end

    // read and write of one period ride in one entry, so neither waits
    assign k_op         = op_of(k_rd, k_wr);
    assign cmd_in_valid = (k_op != dpb_pkg::DPB_OP_NONE);
    assign cmd_in_data  = {k_rd, k_wr, k_raddr, k_waddr, k_w1, k_w0};

    // the controller cannot be stalled; a full buffer can only be reported
    always_ff @(posedge clk_k or negedge k_resetn) begin
        if (!k_resetn) begin
            overrun <= 1'b0;
        end else if (cmd_in_valid && !cmd_in_ready) begin
            overrun <= 1'b1;
        end
    end

    // commands cross into the core domain in order
    dpb_fifo #(
        .WIDTH (CMD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_cmd_fifo (
        .wr_clk    (clk_k),
        .wr_resetn (k_resetn),
        .in_valid  (cmd_in_valid),
        .in_ready  (cmd_in_ready),
        .in_data   (cmd_in_data),
        .rd_clk    (clk_sys),
        .rd_resetn (sys_resetn),
        .out_valid (cmd_out_valid),
        .out_ready (cmd_out_ready),
        .out_data  (cmd_out_data)
    );

    // ---------------------------------------------------------------
    // core: self-timed write and read of the array
    // ---------------------------------------------------------------
    assign sys_op     = op_of(cmd_out_data[RD_BIT], cmd_out_data[WR_BIT]);
    assign sys_rd     = (sys_op == dpb_pkg::DPB_OP_READ) || (sys_op == dpb_pkg::DPB_OP_BOTH);
    assign sys_wr     = (sys_op == dpb_pkg::DPB_OP_WRITE) || (sys_op == dpb_pkg::DPB_OP_BOTH);
    assign sys_raddr  = cmd_out_data[RA_LSB +: ADDR_W];
    assign sys_waddr  = cmd_out_data[WA_LSB +: ADDR_W];
    assign sys_wburst = {cmd_out_data[W1_LSB +: DATA_W], cmd_out_data[W0_LSB +: DATA_W]};

    // a read only stalls the queue when the return path is full
    assign cmd_out_ready = !sys_rd || ret_in_ready;
    assign sys_fire      = cmd_out_valid && cmd_out_ready;
    assign ret_in_valid  = cmd_out_valid && sys_rd && ret_in_ready;

    // the write of an entry was addressed half a clock before its read,
    // so it is forwarded; older writes are already in the array
    assign sys_rburst = (sys_wr && (sys_waddr == sys_raddr)) ? sys_wburst
                                                             : mem[sys_raddr];

    always_ff @(posedge clk_sys) begin
        if (sys_fire && sys_wr) begin
            mem[sys_waddr] <= sys_wburst;
        end
    end

    // read bursts travel back to the output clock domain
    dpb_fifo #(
        .WIDTH (BURST_W),
        .DEPTH (FIFO_DEPTH)
    ) u_ret_fifo (
        .wr_clk    (clk_sys),
        .wr_resetn (sys_resetn),
        .in_valid  (ret_in_valid),
        .in_ready  (ret_in_ready),
        .in_data   (sys_rburst),
        .rd_clk    (clk_c),
        .rd_resetn (c_resetn),
        .out_valid (ret_out_valid),
        .out_ready (1'b1),
        .out_data  (ret_out_data)
    );

    // ---------------------------------------------------------------
    // output registers on the output clock pair
    // ---------------------------------------------------------------
    always_ff @(posedge clk_c or negedge c_resetn) begin
        if (!c_resetn) begin
            q_rise  <= '0;
            c_w1    <= '0;
            q_valid <= 1'b0;
        end else begin
            q_valid <= ret_out_valid;
            if (ret_out_valid) begin
                q_rise <= ret_out_data[W0_LSB +: DATA_W];
                c_w1   <= ret_out_data[W1_LSB +: DATA_W];
            end
        end
    end

    // word 1 goes out half an output clock after word 0
    always_ff @(posedge clk_cn or negedge cn_resetn) begin
        if (!cn_resetn) begin
            q_fall <= '0;
        end else begin
            q_fall <= c_w1;
        end
    end

    // echo clocks run free and change with every launched word phase
    always_ff @(posedge clk_c or negedge c_resetn) begin
        if (!c_resetn) begin
            echo_clock <= 1'b0;
        end else begin
            echo_clock <= !echo_clock;
        end
    end

    always_ff @(posedge clk_cn or negedge cn_resetn) begin
        if (!cn_resetn) begin
            echo_clock_n <= 1'b0;
        end else begin
            echo_clock_n <= !echo_clock_n;
        end
    end

endmodule : dpb_sram

// file: test/dpb_sram_checker.sv
// port assertions for the burst sram interface
`timescale 1ns/10ps
module dpb_sram_checker #(
    parameter int DATA_W     = 18,
    parameter int ADDR_W     = 8,
    parameter int FIFO_DEPTH = 8
) (
    // clocks and reset
    input wire logic              clk_sys,
    input wire logic              resetn,
    input wire logic              clk_k,
    input wire logic              clk_kn,
    input wire logic              clk_c,
    input wire logic              clk_cn,
    // link inputs
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              read_sel_n,
    input wire logic              write_sel_n,
    input wire logic [DATA_W-1:0] d,
    // device outputs
    input wire logic [DATA_W-1:0] q_rise,
    input wire logic [DATA_W-1:0] q_fall,
    input wire logic              q_valid,
    input wire logic              echo_clock,
    input wire logic              echo_clock_n,
    input wire logic              overrun
);
    logic [15:0] read_cnt;
    logic [15:0] burst_cnt;
    logic [1:0]  warm;

    // counts cross domains; only meaningful in simulation
    always_ff @(posedge clk_k or negedge resetn) begin
        if (!resetn) begin
            read_cnt <= 16'h0000;
        end else if (!read_sel_n) begin
            read_cnt <= read_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_c or negedge resetn) begin
        if (!resetn) begin
            burst_cnt <= 16'h0000;
            warm      <= 2'h0;
        end else begin
            burst_cnt <= burst_cnt + {15'h0000, q_valid};
            warm      <= (warm == 2'h3) ? warm : warm + 2'h1;
        end
    end

    sequence echo_up_s;
        $rose(echo_clock);
    endsequence
    sequence echo_down_s;
        $fell(echo_clock);
    endsequence

    echo_rise_a: assert property (@(posedge clk_c) disable iff (!resetn)
        echo_up_s |=> echo_down_s) else $error("echo clock did not fall");
    echo_fall_a: assert property (@(posedge clk_c) disable iff (!resetn)
        echo_down_s |=> echo_up_s) else $error("echo clock did not rise");
    echo_pair_a: assert property (@(posedge clk_c) disable iff (!resetn)
        (warm == 2'h3) |-> (echo_clock_n != $past(echo_clock_n)))
        else $error("inverted echo clock stalled");
    read_return_a: assert property (@(posedge clk_k) disable iff (!resetn)
        !read_sel_n |-> ##[1:20] q_valid) else $error("read burst never returned");
    burst_count_a: assert property (@(posedge clk_c) disable iff (!resetn)
        q_valid |-> (burst_cnt < read_cnt)) else $error("burst without a read");
    last_burst_a: assert property (@(posedge clk_c) disable iff (!resetn)
        q_valid && (read_cnt - burst_cnt == 16'h0001) |=> !q_valid)
        else $error("extra burst returned");
    rise_hold_a: assert property (@(posedge clk_c) disable iff (!resetn)
        !q_valid |-> $stable(q_rise)) else $error("rise word moved without burst");
    fall_hold_a: assert property (@(posedge clk_cn) disable iff (!resetn)
        !$past(q_valid) |-> $stable(q_fall)) else $error("fall word moved without burst");
    overrun_sticky_a: assert property (@(posedge clk_k) disable iff (!resetn)
        overrun |=> overrun) else $error("overrun flag cleared");
endmodule : dpb_sram_checker

bind dpb_sram dpb_sram_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .FIFO_DEPTH(FIFO_DEPTH))
    chk_u (.clk_sys(clk_sys), .resetn(resetn), .clk_k(clk_k), .clk_kn(clk_kn), .clk_c(clk_c),
           .clk_cn(clk_cn), .addr(addr), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
           .d(d), .q_rise(q_rise), .q_fall(q_fall), .q_valid(q_valid),
           .echo_clock(echo_clock), .echo_clock_n(echo_clock_n), .overrun(overrun));

// file: test/dpb_ctl_model.sv
// memory controller model: link clocks, slot driver and burst capture
`timescale 1ns/10ps
module dpb_ctl_model #(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 8
) (
    // link clocks
    output logic                   clk_k,
    output logic                   clk_kn,
    output logic                   clk_c,
    output logic                   clk_cn,
    // command and write data
    output logic [ADDR_W-1:0]      addr,
    output logic                   read_sel_n,
    output logic                   write_sel_n,
    output logic [DATA_W-1:0]      d,
    // read return
    input  wire logic [DATA_W-1:0] q_rise,
    input  wire logic [DATA_W-1:0] q_fall,
    input  wire logic              q_valid
);
    logic [2*DATA_W-1:0] got_q [$];
    logic [DATA_W-1:0]   pend_w1;
    logic                wr_pend;

    initial begin
        clk_k       = 1'b0;
        addr        = '0;
        read_sel_n  = 1'b1;
        write_sel_n = 1'b1;
        d           = '0;
        wr_pend     = 1'b0;
        // odd offset keeps the link unrelated to the core clock
        #7;
        forever #15 clk_k = ~clk_k;
    end
    assign clk_kn = ~clk_k;
    // single clock wiring for the output registers
    assign clk_c  = clk_k;
    assign clk_cn = clk_kn;

    // one link period: read slot on the true rise, write slot on the complementary rise
    task automatic slot(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
                        input logic [ADDR_W-1:0] wa, input logic [2*DATA_W-1:0] wd);
        @(posedge clk_kn);
        addr        <= ra;
        read_sel_n  <= ~rd;
        write_sel_n <= 1'b1;
        d           <= wr_pend ? pend_w1 : ~d;
        @(posedge clk_k);
        addr        <= wa;
        write_sel_n <= ~wr;
        read_sel_n  <= 1'b1;
        d           <= wd[DATA_W-1:0];
        pend_w1 = wd[2*DATA_W-1:DATA_W];
        wr_pend = wr;
    endtask : slot

    // fall word has settled half a period after the valid edge
    always @(posedge clk_c) begin
        if (q_valid === 1'b1) begin
            got_q.push_back({q_fall, q_rise});
        end
    end
endmodule : dpb_ctl_model

// file: test/dpb_sram_test.sv
// self-checking bench for the burst sram interface
`timescale 1ns/10ps
module dpb_sram_test;
    localparam int DW = 18;
    localparam int AW = 8;

    logic            clk_sys;
    logic            resetn;
    logic            clk_k, clk_kn, clk_c, clk_cn;
    logic [AW-1:0]   addr;
    logic            read_sel_n, write_sel_n, q_valid;
    logic [DW-1:0]   d, q_rise, q_fall;
    logic            echo_clock, echo_clock_n, overrun;
    int              failures;
    int              cmp_count;
    logic [2*DW-1:0] mem [256];
    logic [2*DW-1:0] exp_q [$];
    logic [AW-1:0]   tab [6] = '{8'h00, 8'hff, 8'h01, 8'h80, 8'h55, 8'haa};

    dpb_sram #(.DATA_W(DW), .ADDR_W(AW), .FIFO_DEPTH(8)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .clk_k(clk_k), .clk_kn(clk_kn),
        .clk_c(clk_c), .clk_cn(clk_cn), .addr(addr), .read_sel_n(read_sel_n),
        .write_sel_n(write_sel_n), .d(d), .q_rise(q_rise), .q_fall(q_fall),
        .q_valid(q_valid), .echo_clock(echo_clock), .echo_clock_n(echo_clock_n),
        .overrun(overrun));

    dpb_ctl_model #(.DATA_W(DW), .ADDR_W(AW)) ctl_u (
        .clk_k(clk_k), .clk_kn(clk_kn), .clk_c(clk_c), .clk_cn(clk_cn), .addr(addr),
        .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .d(d), .q_rise(q_rise),
        .q_fall(q_fall), .q_valid(q_valid));

    task automatic check(input string what, input logic [2*DW-1:0] seen,
                         input logic [2*DW-1:0] want);
        cmp_count++;
        if (seen !== want) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // a read in a slot is taken before that slot's write lands
    task automatic op(input logic rd, input logic [AW-1:0] ra, input logic wr,
                      input logic [AW-1:0] wa, input logic [2*DW-1:0] wd);
        if (rd) begin
            exp_q.push_back(mem[ra]);
        end
        if (wr) begin
            mem[wa] = wd;
        end
        ctl_u.slot(rd, ra, wr, wa, wd);
    endtask : op

    task automatic idle();
        op(1'b0, 8'h00, 1'b0, 8'h00, 36'h000000000);
    endtask : idle

    task automatic drain();
        int n;
        n = 0;
        while (ctl_u.got_q.size() < exp_q.size() && n < 30) begin
            idle();
            n++;
        end
        if (ctl_u.got_q.size() < exp_q.size()) begin
            failures++;
            print_verdict();
        end else begin
            repeat (10) idle();
            check("burst count", 36'(ctl_u.got_q.size()), 36'(exp_q.size()));
            while (exp_q.size() > 0 && ctl_u.got_q.size() > 0) begin
                check("burst data", ctl_u.got_q.pop_front(), exp_q.pop_front());
            end
        end
    endtask : drain

    // back-to-back writes at edge addresses, then reads in reverse order
    task automatic sc_burst_rw();
        for (int i = 0; i < 6; i++) begin
            op(1'b0, 8'h00, 1'b1, tab[i], {2{18'(i)}} ^ 36'h123456789);
        end
        for (int i = 5; i >= 0; i--) begin
            op(1'b1, tab[i], 1'b0, 8'h00, 36'h000000000);
        end
        drain();
    endtask : sc_burst_rw

    // read and write in one slot; next slot reads the write still in flight
    task automatic sc_concurrent();
        op(1'b1, 8'h00, 1'b1, 8'h01, 36'h0aaaa5555);
        op(1'b1, 8'h01, 1'b1, 8'hff, 36'h3c3c3c3c3);
        op(1'b1, 8'hff, 1'b1, 8'hff, 36'h0f0f0f0f0);
        op(1'b1, 8'hff, 1'b0, 8'h00, 36'h000000000);
        drain();
    endtask : sc_concurrent

    // address and data shown with both selects idle must change nothing
    task automatic sc_select();
        op(1'b0, 8'h55, 1'b0, 8'h55, 36'hfffffffff);
        op(1'b0, 8'h55, 1'b0, 8'h55, 36'h000000000);
        op(1'b1, 8'h55, 1'b0, 8'h00, 36'h000000000);
        drain();
    endtask : sc_select

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        resetn    = 1'b0;
        failures  = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) idle();
        sc_burst_rw();
        sc_concurrent();
        sc_select();
        check("overrun", 36'(overrun), 36'h000000000);
        print_verdict();
    end
endmodule : dpb_sram_test
